// file: src/iss_consts.svh
// Overview of operation
// - group command gates stop on addressing
// - smart mode acks on data read
// - enable-clear register clears enables
// - enable-set register sets enables
// - both registers share one enable vector
// - error flag from four error statuses
// - byte-done set on byte complete
// - byte-done cleared by data write, smart-mode data read, command
// - address-hit set on match, command clears
// - clearing address-hit sends configured acknowledge
// - stop flag only for own transactions
// - stop flag cleared on next command
// - flags clear on write one
// - high-speed status set, cleared by stop
// - extend timeout status and its clears
// - clock stretching while address-hit or byte-done pending
// - reserved bits read zero
// - acknowledge action zero ack, one nack
// - command three answers address hit
`ifndef ISS_CONSTS_SVH
`define ISS_CONSTS_SVH
`define ISS_OFF_CONTROL_B    6'h04
`define ISS_OFF_IENCLR   6'h14
`define ISS_OFF_IENSET   6'h16
`define ISS_OFF_IFLAG    6'h18
`define ISS_OFF_STATUS   6'h1A
`define ISS_OFF_DATA     6'h28
`define ISS_B_SMART_MODE_ENABLE       8
`define ISS_B_GROUP_COMMAND_ENABLE       9
`define ISS_B_CMD_LO     16
`define ISS_B_ACKNOWLEDGE_ACTION     18
`define ISS_B_STOP       0
`define ISS_B_ADDR       1
`define ISS_B_BYTE       2
`define ISS_B_ERR        7
`define ISS_B_BUS_FAULT     0
`define ISS_B_TX_CLASH       1
`define ISS_B_LOWTO      6
`define ISS_B_HOLD       7
`define ISS_B_EXTTO      9
`define ISS_B_HS         10
`define ISS_FLAG_MASK    8'h87
`define ISS_RST_8        8'h00
`define ISS_CMD_ADDR     2'h3
`define ISS_CMD_DONE     2'h2
`endif

// file: src/iss_pkg.sv
package iss_pkg;
    // kind of acknowledge event issued to the bus engine
    typedef enum logic [2:0]
    {
        ISS_ACK_IDLE = 3'b001,
        ISS_ACK_SEND = 3'b010,
        ISS_ACK_HOLD = 3'b100
    } iss_ack_e;
    typedef logic [7:0] iss_byte_t;
endpackage : iss_pkg

// file: src/iss_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; a change counts when stages two and three agree
module iss_sync #(
    parameter int W = 1
) (
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] level_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] lvl_q;

    // first stage feeds only the second
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            lvl_q <= '0;
        end
        else
        begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < W; i++)
            begin
                if (s2_q[i] == s3_q[i])
                begin
                    lvl_q[i] <= s3_q[i];
                end
            end
        end
    end

    assign level_o = lvl_q;
endmodule : iss_sync
`default_nettype wire

// file: src/iss_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "iss_consts.svh"
// interrupt, flag and status logic of the i2c slave
module iss_core
    import iss_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic [5:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    input  wire logic [9:0]  ev_async_i,
    output logic             irq_o,
    output logic             ack_go_o,
    output logic             nack_o,
    output logic             clock_stretching_o
);
    // event inputs come from the bus engine's domain, bit by bit:
    // 0 stop, 1 address hit, 2 byte done, 3 master code after start,
    // 4 extend timeout, 5 low timeout, 6 clash, 7 bus fault,
    // 8 byte read direction (1 = master read), 9 start seen
    logic [9:0] ev_lvl;
    logic [9:0] ev_prev_q;
    logic [9:0] ev_rise;

    iss_sync #(
        .W (10)
    ) u_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .async_i (ev_async_i),
        .level_o (ev_lvl)
    );

    typedef struct packed {
        logic        smart_mode_enable;
        logic        group_command_enable;
        logic        acknowledge_action;
        iss_byte_t   irq_enable;
        iss_byte_t   irq_flags;
        logic        high_speed_seen;
        logic        extend_timeout;
        logic        scl_low_timeout;
        logic        tx_clash;
        logic        bus_fault;
        logic        addressed;
        iss_ack_e    ack_state;
        logic        ack_nack;
        logic        irq;
        logic [31:0] rdata;
    } iss_state_s;

    iss_state_s st_q;
    iss_state_s st_d;

    // true when the address matches a given register offset
    function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
        hit = (a == off);
    endfunction : hit

    // edge detect on the settled (not first-stage) levels
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            ev_prev_q <= '0;
        end
        else
        begin
            ev_prev_q <= ev_lvl;
        end
    end
    assign ev_rise = ev_lvl & ~ev_prev_q;

    // next-state logic; hardware sets win over software clears
    always_comb
    begin
        logic       wr_ctrl;
        logic       cmd_valid;
        logic       cmd_addr;
        logic       ack_now;
        logic [7:0] w1c;
        logic       addr_cleared;
        logic       err_ev;
        wr_ctrl      = 1'b0;
        cmd_valid    = 1'b0;
        cmd_addr     = 1'b0;
        ack_now      = 1'b0;
        w1c          = 8'h00;
        addr_cleared = 1'b0;
        err_ev       = 1'b0;
        st_d         = st_q;

        wr_ctrl   = wr_i && hit(addr_i, `ISS_OFF_CONTROL_B);
        cmd_valid = wr_ctrl && wdata_i[`ISS_B_CMD_LO+1];
        cmd_addr  = wr_ctrl
            && (wdata_i[`ISS_B_CMD_LO+1:`ISS_B_CMD_LO] == `ISS_CMD_ADDR);

        // control bits
        if (wr_ctrl)
        begin
            st_d.smart_mode_enable    = wdata_i[`ISS_B_SMART_MODE_ENABLE];
            st_d.group_command_enable = wdata_i[`ISS_B_GROUP_COMMAND_ENABLE];
            st_d.acknowledge_action   = wdata_i[`ISS_B_ACKNOWLEDGE_ACTION];
        end

        if (wr_i && hit(addr_i, `ISS_OFF_IENCLR))
        begin
            st_d.irq_enable = st_q.irq_enable & ~(wdata_i[7:0] & `ISS_FLAG_MASK);
        end
        if (wr_i && hit(addr_i, `ISS_OFF_IENSET))
        begin
            st_d.irq_enable = st_q.irq_enable | (wdata_i[7:0] & `ISS_FLAG_MASK);
        end

        if (wr_i && hit(addr_i, `ISS_OFF_IFLAG))
        begin
            w1c = wdata_i[7:0] & `ISS_FLAG_MASK;
        end
        if (cmd_valid)
        begin
            w1c = w1c | 8'h07;
        end
        // data write or smart read clears byte-done
        if ((wr_i && hit(addr_i, `ISS_OFF_DATA))
            || (rd_i && hit(addr_i, `ISS_OFF_DATA) && st_q.smart_mode_enable))
        begin
            w1c[`ISS_B_BYTE] = 1'b1;
        end
        addr_cleared = w1c[`ISS_B_ADDR] && st_q.irq_flags[`ISS_B_ADDR];
        st_d.irq_flags = st_q.irq_flags & ~w1c;

        // high speed clears by write one or stop
        if (wr_i && hit(addr_i, `ISS_OFF_STATUS))
        begin
            if (wdata_i[`ISS_B_HS])     st_d.high_speed_seen = 1'b0;
            if (wdata_i[`ISS_B_EXTTO])  st_d.extend_timeout  = 1'b0;
            if (wdata_i[`ISS_B_LOWTO])  st_d.scl_low_timeout = 1'b0;
            if (wdata_i[`ISS_B_TX_CLASH])   st_d.tx_clash        = 1'b0;
            if (wdata_i[`ISS_B_BUS_FAULT]) st_d.bus_fault       = 1'b0;
        end
        if (ev_rise[0])
        begin
            st_d.high_speed_seen = 1'b0;
        end
        if (cmd_addr || addr_cleared)
        begin
            st_d.extend_timeout  = 1'b0;
            st_d.scl_low_timeout = 1'b0;
            st_d.tx_clash        = 1'b0;
            st_d.bus_fault       = 1'b0;
        end

        if (ev_rise[3])
        begin
            st_d.high_speed_seen = 1'b1;
        end
        if (ev_rise[4]) st_d.extend_timeout  = 1'b1;
        if (ev_rise[5]) st_d.scl_low_timeout = 1'b1;
        if (ev_rise[6]) st_d.tx_clash        = 1'b1;
        if (ev_rise[7]) st_d.bus_fault       = 1'b1;
        err_ev = |ev_rise[7:4];
        if (err_ev) st_d.irq_flags[`ISS_B_ERR] = 1'b1;
        if (ev_rise[2]) st_d.irq_flags[`ISS_B_BYTE] = 1'b1;
        if (ev_rise[1])
        begin
            st_d.irq_flags[`ISS_B_ADDR] = 1'b1;
            st_d.addressed              = 1'b1;
        end
        if (ev_rise[0])
        begin
            if (st_q.addressed || ev_rise[1])
            begin
                st_d.irq_flags[`ISS_B_STOP] = 1'b1;
            end
            st_d.addressed = 1'b0;
        end
        // without group command, a repeated start ends tracking unless address-hit is still pending
        if (ev_rise[9] && !st_q.group_command_enable && !ev_rise[1])
        begin
            st_d.addressed = st_q.addressed && st_q.irq_flags[`ISS_B_ADDR];
        end

        ack_now = addr_cleared || cmd_addr
            || (cmd_valid && !wdata_i[`ISS_B_CMD_LO] && !ev_lvl[8])
            || (rd_i && hit(addr_i, `ISS_OFF_DATA) && st_q.smart_mode_enable);
        st_d.ack_nack  = st_q.acknowledge_action;
        st_d.ack_state = ack_now ? ISS_ACK_SEND : ISS_ACK_IDLE;
        if (wr_ctrl && ack_now)
        begin
            st_d.ack_nack = wdata_i[`ISS_B_ACKNOWLEDGE_ACTION];
        end

        st_d.irq = |(st_d.irq_flags & st_d.irq_enable);

        // read data one cycle later; reserved read zero
        st_d.rdata = 32'h0000_0000;
        if (rd_i)
        begin
            case (addr_i)
                `ISS_OFF_CONTROL_B:
                begin
                    st_d.rdata[`ISS_B_SMART_MODE_ENABLE]   = st_q.smart_mode_enable;
                    st_d.rdata[`ISS_B_GROUP_COMMAND_ENABLE]   = st_q.group_command_enable;
                    st_d.rdata[`ISS_B_ACKNOWLEDGE_ACTION] = st_q.acknowledge_action;
                end
                `ISS_OFF_IENCLR, `ISS_OFF_IENSET: st_d.rdata[7:0] = st_q.irq_enable;
                `ISS_OFF_IFLAG:  st_d.rdata[7:0] = st_q.irq_flags;
                `ISS_OFF_STATUS:
                begin
                    st_d.rdata[`ISS_B_HS]     = st_q.high_speed_seen;
                    st_d.rdata[`ISS_B_EXTTO]  = st_q.extend_timeout;
                    st_d.rdata[`ISS_B_HOLD]   = |st_q.irq_flags[2:1];
                    st_d.rdata[`ISS_B_LOWTO]  = st_q.scl_low_timeout;
                    st_d.rdata[`ISS_B_TX_CLASH]   = st_q.tx_clash;
                    st_d.rdata[`ISS_B_BUS_FAULT] = st_q.bus_fault;
                end
                default: st_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // single state register
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            st_q            <= '0;
            st_q.ack_state  <= ISS_ACK_IDLE;
            st_q.irq_enable <= `ISS_RST_8;
            st_q.irq_flags  <= `ISS_RST_8;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // stretching register, registered so the pin has no glitch
    logic hold_q;
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            hold_q <= 1'b0;
        end
        else
        begin
            hold_q <= |st_d.irq_flags[2:1];
        end
    end

    assign rdata_o            = st_q.rdata;
    assign irq_o              = st_q.irq;
    assign ack_go_o           = (st_q.ack_state == ISS_ACK_SEND);
    assign nack_o             = st_q.ack_nack;
    assign clock_stretching_o = hold_q;
endmodule : iss_core
`default_nettype wire

// file: test/iss_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// bus engine stand-in: each requested event becomes a level pulse
module iss_engine_model (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic [9:0] fire_i,
    input  wire logic       dir_i,
    output logic      [9:0] ev_o
);
    logic [2:0] hold_q [10];

    // four cycles high, then at least four low before the next event
    always_ff @(posedge clock_i)
    begin
        for (int i = 0; i < 10; i++)
        begin
            if (rst_i)
                hold_q[i] <= 3'h0;
            else if (fire_i[i] && hold_q[i] == 3'h0)
                hold_q[i] <= 3'h7;
            else if (hold_q[i] != 3'h0)
                hold_q[i] <= hold_q[i] - 3'h1;
        end
    end

    // bit 8 is a level, not an event
    always_comb
    begin
        for (int i = 0; i < 10; i++)
            ev_o[i] = (hold_q[i] > 3'h3);
        ev_o[8] = dir_i;
    end
endmodule : iss_engine_model
`default_nettype wire

// file: test/iss_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module iss_core_asserts (
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic [5:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [9:0]  ev_async_i,
    input wire logic        irq_o,
    input wire logic        ack_go_o,
    input wire logic        nack_o,
    input wire logic        clock_stretching_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    // read data only in the answer cycle
    a_rdata_idle : assert property (
        !rd_i |=> rdata_o == 32'h0) else $error("read data outside answer cycle");
    a_flags_reserved : assert property (
        rd_i && addr_i == 6'h18 |=> rdata_o[31:8] == 24'h0 && rdata_o[6:3] == 4'h0)
        else $error("flag reserved bits set");
    a_status_reserved : assert property (
        rd_i && addr_i == 6'h1A |=> rdata_o[31:11] == 21'h0 && rdata_o[8] == 1'b0)
        else $error("status reserved bits set");
    a_cmd_reads_zero : assert property (
        rd_i && addr_i == 6'h04 |=> rdata_o[17:16] == 2'h0 && rdata_o[7:0] == 8'h00)
        else $error("control strobe bits read back");
    // set and clear views share one vector
    a_set_shown : assert property (
        wr_i && addr_i == 6'h16 ##2 rd_i && addr_i == 6'h14
        |=> (rdata_o[7:0] & $past(wdata_i[7:0], 3) & 8'h87) == ($past(wdata_i[7:0], 3) & 8'h87))
        else $error("set enable not seen in clear view");
    a_clr_shown : assert property (
        wr_i && addr_i == 6'h14 ##2 rd_i && addr_i == 6'h16
        |=> (rdata_o[7:0] & $past(wdata_i[7:0], 3)) == 8'h00)
        else $error("cleared enable still seen");
    a_irq_masked : assert property (
        wr_i && addr_i == 6'h14 && (wdata_i[7:0] & 8'h87) == 8'h87 ##1 !(wr_i && addr_i == 6'h16)
        |=> !irq_o) else $error("interrupt with all enables off");
    // events quiet, so clearing both pending flags must drop the hold
    a_stretch_drop : assert property (
        (ev_async_i[2:1] == 2'b00) [*8] ##0 (wr_i && addr_i == 6'h18 && wdata_i[2:1] == 2'b11)
        |=> ##1 !clock_stretching_o) else $error("clock hold kept after flags cleared");
    a_cmd3_ack : assert property (
        wr_i && addr_i == 6'h04 && wdata_i[17:16] == 2'h3
        |=> ack_go_o && nack_o == $past(wdata_i[18])) else $error("command three no acknowledge");
    a_ack_quiet : assert property (
        !wr_i && !rd_i |=> !ack_go_o) else $error("acknowledge without software access");
endmodule : iss_core_asserts

bind iss_core iss_core_asserts chk_i (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ev_async_i(ev_async_i),
    .irq_o(irq_o), .ack_go_o(ack_go_o), .nack_o(nack_o),
    .clock_stretching_o(clock_stretching_o));
`default_nettype wire

// file: test/i2c_slave_irq_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_irq_status_tb;
    typedef struct packed
    {
        logic [5:0]  wa;
        logic [31:0] wd;
        logic [5:0]  ra;
        logic [31:0] ex;
    } iss_row_s;
    logic        clock_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [5:0]  addr_i = 6'h00;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [9:0]  fire = 10'h000;
    logic        dir = 1'b0;
    logic [31:0] rdata_o;
    logic [9:0]  ev;
    logic        irq_o;
    logic        ack_go_o;
    logic        nack_o;
    logic        clock_stretching_o;
    int          n_errors = 0;
    int          num_checks = 0;
    // unmapped writes first double as reset-value reads
    iss_row_s rows [11] = '{'{6'h3E, 32'h0, 6'h04, 32'h0}, '{6'h3E, 32'h0, 6'h14, 32'h0},
        '{6'h3E, 32'h0, 6'h16, 32'h0}, '{6'h3E, 32'h0, 6'h18, 32'h0},
        '{6'h3E, 32'h0, 6'h1A, 32'h0}, '{6'h16, 32'h87, 6'h14, 32'h87},
        '{6'h14, 32'h05, 6'h16, 32'h82}, '{6'h16, 32'h00, 6'h16, 32'h82},
        '{6'h14, 32'hFF, 6'h16, 32'h0}, '{6'h3E, 32'hFFFFFFFF, 6'h3E, 32'h0},
        '{6'h04, 32'h00040300, 6'h04, 32'h00040300}};

    always #2.5 clock_i = ~clock_i;

    iss_core uut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ev_async_i(ev), .irq_o(irq_o),
        .ack_go_o(ack_go_o), .nack_o(nack_o), .clock_stretching_o(clock_stretching_o));
    iss_engine_model far (.clock_i(clock_i), .rst_i(rst_i), .fire_i(fire), .dir_i(dir),
        .ev_o(ev));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        num_checks++;
        if (seen !== ex)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, ex, seen);
        end
    endtask : chk

    // strobes drop one edge after launch, so calls never collide
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [5:0] a, input string nm, input logic [31:0] ex);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        chk(nm, rdata_o, ex);
    endtask : rd

    // wait covers the synchroniser and the flag register
    task automatic ev_pulse(input logic [9:0] m);
        @(posedge clock_i);
        fire <= m;
        @(posedge clock_i);
        fire <= 10'h000;
        repeat (12) @(posedge clock_i);
    endtask : ev_pulse

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    // whole run is well under a thousand cycles
    initial
    begin
        repeat (4000) @(posedge clock_i);
        n_errors++;
        give_verdict();
    end

    initial
    begin
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        foreach (rows[i])
        begin
            wr(rows[i].wa, rows[i].wd);
            rd(rows[i].ra, "row", rows[i].ex);
        end
        // stop before any addressing must stay silent
        wr(6'h16, 32'h87);
        wr(6'h04, 32'h00040200);
        ev_pulse(10'h001);
        rd(6'h18, "stop alone", 32'h0);
        ev_pulse(10'h002);
        rd(6'h18, "addr flag", 32'h02);
        chk("stretch", {31'h0, clock_stretching_o}, 32'h1);
        chk("irq", {31'h0, irq_o}, 32'h1);
        wr(6'h14, 32'h87);
        rd(6'h14, "masked", 32'h0);
        chk("irq masked", {31'h0, irq_o}, 32'h0);
        wr(6'h16, 32'h87);
        wr(6'h18, 32'h06);
        chk("w1c ack", {30'h0, ack_go_o, nack_o}, 32'h3);
        rd(6'h1A, "hold off", 32'h0);
        ev_pulse(10'h001);
        ev_pulse(10'h002);
        rd(6'h18, "stop own", 32'h03);
        wr(6'h04, 32'h00030000);
        chk("cmd ack", {30'h0, ack_go_o, nack_o}, 32'h2);
        rd(6'h18, "after cmd", 32'h0);
        // all four error sources at once, then partial clears
        ev_pulse(10'h0F0);
        rd(6'h1A, "errors", 32'h0243);
        rd(6'h18, "err flag", 32'h80);
        wr(6'h1A, 32'h0001);
        wr(6'h18, 32'h0080);
        rd(6'h1A, "status w1c", 32'h0242);
        rd(6'h18, "flag w1c", 32'h0);
        ev_pulse(10'h002);
        wr(6'h18, 32'h06);
        rd(6'h1A, "address_hit clr", 32'h0);
        // extend timeout cleared by command three, then by write one
        ev_pulse(10'h010);
        wr(6'h04, 32'h00030000);
        rd(6'h1A, "ext cmd3", 32'h0);
        ev_pulse(10'h010);
        rd(6'h1A, "ext set", 32'h0200);
        wr(6'h1A, 32'h0200);
        rd(6'h1A, "ext w1c", 32'h0);
        ev_pulse(10'h008);
        rd(6'h1A, "hs", 32'h0400);
        wr(6'h1A, 32'h0400);
        rd(6'h1A, "hs w1c", 32'h0);
        ev_pulse(10'h008);
        rd(6'h1A, "hs again", 32'h0400);
        ev_pulse(10'h001);
        rd(6'h1A, "hs stop", 32'h0);
        // smart mode: data read acknowledges and clears byte done
        wr(6'h18, 32'h87);
        wr(6'h04, 32'h00000100);
        ev_pulse(10'h004);
        rd(6'h18, "byte", 32'h04);
        rd(6'h28, "data", 32'h0);
        chk("smart ack", {30'h0, ack_go_o, nack_o}, 32'h2);
        rd(6'h18, "byte clr", 32'h0);
        // command two acknowledges only while the master writes
        ev_pulse(10'h004);
        wr(6'h04, 32'h00020000);
        chk("cmd2 write", {30'h0, ack_go_o, nack_o}, 32'h2);
        rd(6'h18, "cmd2 clr", 32'h0);
        @(posedge clock_i);
        dir <= 1'b1;
        ev_pulse(10'h004);
        wr(6'h04, 32'h00060000);
        chk("cmd2 read", {31'h0, ack_go_o}, 32'h0);
        rd(6'h18, "cmd2 rd clr", 32'h0);
        @(posedge clock_i);
        dir <= 1'b0;
        // group command keeps tracking across a repeated start
        wr(6'h04, 32'h00000200);
        ev_pulse(10'h002);
        wr(6'h18, 32'h06);
        ev_pulse(10'h200);
        ev_pulse(10'h001);
        rd(6'h18, "group stop", 32'h01);
        wr(6'h04, 32'h00000000);
        ev_pulse(10'h002);
        wr(6'h18, 32'h07);
        ev_pulse(10'h200);
        ev_pulse(10'h001);
        rd(6'h18, "plain stop", 32'h0);
        // pending flag before a mid-run reset, all quiet after it
        ev_pulse(10'h002);
        #1;
        chk("pre reset", {30'h0, irq_o, clock_stretching_o}, 32'h3);
        @(posedge clock_i);
        rst_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        #1;
        chk("reset out", {28'h0, irq_o, ack_go_o, nack_o, clock_stretching_o}, 32'h0);
        rd(6'h18, "reset flags", 32'h0);
        rd(6'h16, "reset", 32'h0);
        give_verdict();
    end
endmodule : i2c_slave_irq_status_tb
`default_nettype wire
